// *** hw/lbc_pkg.sv ***
// Purpose: shared constants and carriers for the local bus control block
// Assumes: one 40 MHz board clock; cpu pins arrive synchronous to it
// Notes:   Operation list below; tags mark the logic that carries each out
//
// Operation
// RULE1: latch low address on strobe trailing edge
// RULE2: route address fields to io, rom, ram decoders
// RULE3: strobe restarts 10 ms watchdog; expiry flags timeout
// RULE4: optional link: timeout forces cpu ready high
// RULE5: timeout release raises hang-up interrupt when routed
// RULE6: common command active on read or write
// RULE7: io flag buffers status; io write strobe gated
// RULE8: memory flag inverts status; memory write gated
// RULE9: early commands only in memory cycles; bit0 selects
// RULE10: read or fetch registers early read
// RULE11: memory write registers early write command
// RULE12: strobe end sets done; done clears early commands
// RULE13: cpu wins ram; external waits for cpu end
// RULE14: external owner mode holds off cpu requests
// RULE15: request plus command sets sync and lock
// RULE16: owner flag set after p1, held by lock
// RULE17: external select after p2 gates external command
// RULE18: sync stage clears once controller acknowledges
// RULE19: master drops command before dropping request
// RULE20: lock, owner, select release on successive edges
// RULE21: cpu access passes commands, acks, aborts sync
// RULE22: pending external request restarts after cpu access
// RULE23: reset clears all arbiter and early registers
package lbc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TMO_MS = 10;
    localparam int unsigned TMO_CYC = (CLK_HZ / 1000) * TMO_MS;
    // ------------------------------------------------------------
    // address field positions
    // ------------------------------------------------------------
    localparam int unsigned IO_DEC_LSB = 2;
    localparam int unsigned IO_DEC_MSB = 7;
    localparam int unsigned ROM_DEC_LSB = 10;
    localparam int unsigned RAM_DEC_LSB = 13;
    localparam int unsigned ADDR_MSB = 15;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RST_FLAG = 1'b0;
    localparam logic [7:0] RST_ADDR = 8'h00;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic iom;        // high for io cycles
        logic status_bit_one;
        logic status_bit_zero;
        logic rd_n;
        logic wr_n;
    } lbc_cpu_t;
    typedef struct packed {
        logic ext_ram_request_n;
        logic ext_ram_read_n;
        logic ext_ram_write_n;
    } lbc_ext_t;
    typedef struct packed {
        logic early_read_cmd_n;
        logic early_write_cmd_n;
    } lbc_early_t;
endpackage

// *** hw/lbc_watchdog.sv ***
// Purpose: retriggerable bus timeout watchdog
// Assumes: ale_rise_in is a one-cycle pulse
// Notes:   counter saturates so the timeout stays up until retriggered
module lbc_watchdog #(
    parameter int unsigned TIMEOUT_CYCLES = lbc_pkg::TMO_CYC
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // events and options
    input wire logic ale_rise_in,
    input wire logic irq_route_en_in,
    // results
    output logic bus_timeout_out,
    output logic hang_irq_out
);
    localparam int unsigned CW = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT_CYCLES);
    logic [CW-1:0] cnt_q, cnt_d;
    logic tmo_q, tmo_d, irq_q, irq_d;

    // restart on every strobe, saturate at the limit
    always_comb begin
        cnt_d = cnt_q;
        if (ale_rise_in) begin
            cnt_d = '0;                               // [RULE3]
        end else if (cnt_q != LIMIT) begin
            cnt_d = cnt_q + 1'b1;
        end
        tmo_d = (cnt_d == LIMIT);                     // [RULE3]
        // active-high timeout falls when a strobe ends the hang-up
        irq_d = irq_route_en_in & tmo_q & ~tmo_d;     // [RULE5]
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= '0;
            tmo_q <= lbc_pkg::RST_FLAG;
            irq_q <= lbc_pkg::RST_FLAG;
        end else begin
            cnt_q <= cnt_d;
            tmo_q <= tmo_d;
            irq_q <= irq_d;
        end
    end

    assign bus_timeout_out = tmo_q;
    assign hang_irq_out = irq_q;
endmodule // lbc_watchdog

// *** hw/lbc_early_cmd.sv ***
// Purpose: low address latch and early memory command generation
// Assumes: strobe edges come in as one-cycle pulses from the top
// Notes:   early commands are ahead of the cpu strobes by one state
module lbc_early_cmd (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // cpu side
    input wire logic ale_in,
    input wire logic ale_fall_in,
    input wire logic ale_rise_in,
    input wire logic [7:0] ad_in,
    input wire lbc_pkg::lbc_cpu_t cpu_in,
    // results
    output logic [7:0] addr_lo_out,
    output lbc_pkg::lbc_early_t early_out
);
    logic [7:0] lat_q, lat_d;
    logic rd_q, rd_d, wr_q, wr_d, done_q, done_d, cmd_n_q;

    // transparent while strobe high, frozen from its trailing edge
    always_comb begin
        lat_d = ale_in ? ad_in : lat_q;               // [RULE1]
        // set wins over the strobe clear so no completion is lost
        done_d = (cpu_in.rd_n & cpu_in.wr_n & ~cmd_n_q)
               | (done_q & ~ale_rise_in);             // [RULE12]
        rd_d = rd_q;
        wr_d = wr_q;
        if (done_q) begin
            rd_d = 1'b0;                              // [RULE12]
            wr_d = 1'b0;
        end else if (ale_fall_in && !cpu_in.iom) begin // [RULE9]
            rd_d = cpu_in.status_bit_one;             // [RULE10]
            wr_d = cpu_in.status_bit_zero ? ~cpu_in.status_bit_one
                                          : 1'b0;     // [RULE11]
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            lat_q <= lbc_pkg::RST_ADDR;
            rd_q <= lbc_pkg::RST_FLAG;                // [RULE23]
            wr_q <= lbc_pkg::RST_FLAG;
            done_q <= lbc_pkg::RST_FLAG;
            cmd_n_q <= 1'b1;
        end else begin
            lat_q <= lat_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            done_q <= done_d;
            cmd_n_q <= cpu_in.rd_n & cpu_in.wr_n;
        end
    end

    assign addr_lo_out = lat_q;
    assign early_out.early_read_cmd_n = ~rd_q;
    assign early_out.early_write_cmd_n = ~wr_q;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    a_addr_latch: assert property (ale_fall_in |-> lat_q == $past(ad_in)) // [RULE1]
        else $error("low address not held from strobe");
    a_early_read: assert property (
        ale_fall_in && !done_q && !cpu_in.iom && cpu_in.status_bit_one
        |=> !early_out.early_read_cmd_n)                  // [RULE10]
        else $error("early read not raised");
    a_early_write: assert property (
        ale_fall_in && !done_q && !cpu_in.iom && cpu_in.status_bit_zero
        && !cpu_in.status_bit_one |=> !early_out.early_write_cmd_n) // [RULE11]
        else $error("early write not raised");
    a_io_no_early: assert property (
        ale_fall_in && cpu_in.iom && !rd_q && !wr_q |=> !rd_q && !wr_q) // [RULE9]
        else $error("early command in io cycle");
    a_done_clears: assert property (done_q |=> !rd_q && !wr_q) // [RULE12]
        else $error("completion did not clear early command");
endmodule // lbc_early_cmd

// *** hw/lbc_top.sv ***
// Purpose: cpu-side local bus control and dual-port ram arbitration
// Assumes: external master keeps request up until its command drops
// Notes:   the cpu always wins a same-cycle contest for the ram
module lbc_top #(
    parameter int unsigned TIMEOUT_CYCLES = lbc_pkg::TMO_CYC
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // cpu bus
    input wire logic ale_in,
    input wire logic [7:0] ad_in,
    input wire logic [7:0] addr_hi_in,
    input wire lbc_pkg::lbc_cpu_t cpu_in,
    input wire logic local_ram_request_in,
    input wire logic mem_ready_in,
    // option links
    input wire logic ready_link_en_in,
    input wire logic irq_route_en_in,
    // decoder feeds
    output logic [7:0] addr_lo_out,
    output logic [5:0] io_dec_addr_out,
    output logic [5:0] rom_dec_addr_out,
    output logic [2:0] ram_dec_addr_out,
    // read and write strobes
    output logic command_n_out,
    output logic io_cycle_out,
    output logic io_write_strobe_n_out,
    output logic mem_cycle_out,
    output logic memory_write_strobe_n_out,
    output logic memory_read_strobe_n_out,
    output lbc_pkg::lbc_early_t early_out,
    // watchdog
    output logic bus_timeout_out,
    output logic hang_irq_out,
    output logic cpu_ready_out,
    // external master port
    input wire lbc_pkg::lbc_ext_t ext_in,
    output logic bus_transfer_ack_n_out,
    output logic ext_owner_out,
    // ram controller
    input wire logic ram_early_ack_n_in,
    input wire logic ram_transfer_ack_n_in,
    output logic ctrl_port_select_n_out,
    output logic external_select_n_out,
    output logic ram_read_n_out,
    output logic ram_write_n_out,
    output logic cpu_ram_ack_n_out
);
    // ------------------------------------------------------------
    // strobe edges
    // ------------------------------------------------------------
    logic ale_q, ale_fall, ale_rise;
    logic [15:0] addr;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ale_q <= lbc_pkg::RST_FLAG;
        end else begin
            ale_q <= ale_in;
        end
    end

    assign ale_fall = ale_q & ~ale_in;
    assign ale_rise = ~ale_q & ale_in;

    // ------------------------------------------------------------
    // latch, early commands, watchdog
    // ------------------------------------------------------------
    lbc_early_cmd u_early (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .ale_in(ale_in),
        .ale_fall_in(ale_fall),
        .ale_rise_in(ale_rise),
        .ad_in(ad_in),
        .cpu_in(cpu_in),
        .addr_lo_out(addr_lo_out),
        .early_out(early_out)
    );

    lbc_watchdog #(
        .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
    ) u_wdog (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .ale_rise_in(ale_rise),
        .irq_route_en_in(irq_route_en_in),
        .bus_timeout_out(bus_timeout_out),
        .hang_irq_out(hang_irq_out)
    );

    // ------------------------------------------------------------
    // decoder routing and strobes
    // ------------------------------------------------------------
    // io field comes off the low latch; rom and ram fields come straight from addr_hi_in
    assign addr = {addr_hi_in, addr_lo_out};
    assign io_dec_addr_out = addr[lbc_pkg::IO_DEC_MSB:lbc_pkg::IO_DEC_LSB]; // [RULE2]
    assign rom_dec_addr_out = addr[lbc_pkg::ADDR_MSB:lbc_pkg::ROM_DEC_LSB]; // [RULE2]
    assign ram_dec_addr_out = addr[lbc_pkg::ADDR_MSB:lbc_pkg::RAM_DEC_LSB]; // [RULE2]

    // plain gating of the cpu status pins
    assign command_n_out = cpu_in.rd_n & cpu_in.wr_n;                  // [RULE6]
    assign io_cycle_out = cpu_in.iom;                                  // [RULE7]
    assign io_write_strobe_n_out = ~(cpu_in.iom & ~cpu_in.wr_n);       // [RULE7]
    assign mem_cycle_out = ~cpu_in.iom;                                // [RULE8]
    assign memory_write_strobe_n_out = ~(~cpu_in.iom & ~cpu_in.wr_n);  // [RULE8]
    assign memory_read_strobe_n_out = ~(~cpu_in.iom & ~cpu_in.rd_n);

    // timeout releases a cpu parked in wait states, if linked
    assign cpu_ready_out = mem_ready_in
                         | (ready_link_en_in & bus_timeout_out);       // [RULE4]

    // ------------------------------------------------------------
    // dual-port arbiter
    // ------------------------------------------------------------
    logic sync_q, sync_d, lock_q, lock_d;
    logic owner_q, owner_d, sel_q, sel_d;
    logic ext_cmd, ext_go, cpu_active, ram_ack;

    assign ext_cmd = ~ext_in.ext_ram_read_n | ~ext_in.ext_ram_write_n;
    assign ext_go = ~ext_in.ext_ram_request_n & ext_cmd;
    // cpu holds the ram unless the external side already owns it
    assign cpu_active = local_ram_request_in & ~owner_q;               // [RULE13] [RULE14]
    assign ram_ack = ~ram_early_ack_n_in;

    // next state of the four arbiter stages
    always_comb begin
        sync_d = sync_q;
        if (cpu_active) begin
            sync_d = 1'b0;                            // [RULE13] [RULE21]
        end else if (ext_go && !owner_q && !sel_q) begin
            sync_d = 1'b1;                            // [RULE15] [RULE22]
        end else if (sel_q && ram_ack) begin
            sync_d = 1'b0;                            // [RULE18]
        end
        // lock only survives while a sync or owner cycle is live
        lock_d = ext_cmd & ((ext_go & ~cpu_active & ~owner_q & ~sel_q)
               | (lock_q & (sync_q | owner_q)));      // [RULE15] [RULE20]
        // owner sets one period after sync, then lock keeps it
        owner_d = (sync_q & lock_q & ~cpu_active)
                | (owner_q & lock_q);                 // [RULE16] [RULE20]
        sel_d = owner_q;                              // [RULE17] [RULE20]
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_q <= lbc_pkg::RST_FLAG;              // [RULE23]
            lock_q <= lbc_pkg::RST_FLAG;
            owner_q <= lbc_pkg::RST_FLAG;
            sel_q <= lbc_pkg::RST_FLAG;
        end else begin
            sync_q <= sync_d;
            lock_q <= lock_d;
            owner_q <= owner_d;
            sel_q <= sel_d;
        end
    end

    // ------------------------------------------------------------
    // ram controller steering
    // ------------------------------------------------------------
    // the master can only misbehave by dropping request first; the
    // lock watches the command alone so that order is harmless
    always_comb begin
        ram_read_n_out = 1'b1;
        ram_write_n_out = 1'b1;
        if (sel_q) begin
            ram_read_n_out = ext_in.ext_ram_read_n;                  // [RULE17]
            ram_write_n_out = ext_in.ext_ram_write_n;                // [RULE17] [RULE19]
        end else if (cpu_active) begin
            ram_read_n_out = early_out.early_read_cmd_n;             // [RULE21]
            ram_write_n_out = memory_write_strobe_n_out;             // [RULE21]
        end
    end

    assign ctrl_port_select_n_out = ~(sel_q | cpu_active);           // [RULE17]
    assign external_select_n_out = ~sel_q;
    assign ext_owner_out = owner_q;
    assign cpu_ram_ack_n_out = ~(cpu_active & ~sel_q & ram_ack);     // [RULE21]
    assign bus_transfer_ack_n_out = ~(sel_q & ~ram_transfer_ack_n_in);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    a_ready_force: assert property (
        ready_link_en_in && bus_timeout_out |-> cpu_ready_out)       // [RULE4]
        else $error("timeout did not force ready");
    a_tmo_restart: assert property (ale_rise |=> !bus_timeout_out) // [RULE3]
        else $error("strobe did not restart watchdog");
    a_irq_release: assert property (
        hang_irq_out |-> irq_route_en_in ##0 $past(bus_timeout_out)
        && !bus_timeout_out)                                         // [RULE5]
        else $error("hang interrupt without timeout release");
    a_cmd_common: assert property (
        command_n_out == (cpu_in.rd_n & cpu_in.wr_n))                // [RULE6]
        else $error("common command wrong");
    a_io_strobes: assert property (
        io_cycle_out != mem_cycle_out
        && !(io_write_strobe_n_out == 1'b0 && memory_write_strobe_n_out == 1'b0)) // [RULE7]
        else $error("io and memory strobes clash");
    a_no_dual_owner: assert property (!(sel_q && !cpu_ram_ack_n_out)) // [RULE13]
        else $error("cpu acked while external selected");
    a_owner_blocks: assert property (
        owner_q && local_ram_request_in |-> cpu_ram_ack_n_out)       // [RULE14]
        else $error("cpu served during owner mode");
    a_sync_p0: assert property (
        ext_go && !cpu_active && !sync_q && !owner_q && !sel_q
        |=> sync_q && lock_q)                                        // [RULE15]
        else $error("sync and lock not set");
    a_owner_sel: assert property (
        sync_q && lock_q && !owner_q && !cpu_active
        |=> owner_q ##1 sel_q && !external_select_n_out)             // [RULE16]
        else $error("owner then select not reached");
    a_release_seq: assert property (
        $fell(lock_q) && owner_q |=> !owner_q ##1 !sel_q)            // [RULE20]
        else $error("release order broken");
    a_cpu_abort: assert property (cpu_active |=> !sync_q)            // [RULE21]
        else $error("cpu access did not clear sync");

    c_ext_access: cover property (ext_go ##1 sync_q ##1 owner_q ##1 sel_q);
    c_cpu_first: cover property (sync_q && cpu_active ##1 !sync_q);
    c_timeout: cover property ($rose(bus_timeout_out));
    c_hang_irq: cover property (hang_irq_out);
endmodule // lbc_top

// *** verif/lbc_ram_model.sv ***
// Purpose: behavioural ram controller facing the arbiter's ram port
// Assumes: commands and port select are low active and synchronous to mclk_in
// Notes:   ack latency is set per scenario so prompt and slow answers are both seen
module lbc_ram_model (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // arbiter side
    input wire logic port_select_n_in,
    input wire logic read_n_in,
    input wire logic write_n_in,
    input wire logic [3:0] ack_delay_in,
    // answers
    output logic early_ack_n_out,
    output logic transfer_ack_n_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic active;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    // ------------------------------------------------------------
    // access timer
    // ------------------------------------------------------------
    // a dropped command restarts the count, so acks never linger
    always_comb begin
        active = !port_select_n_in && (!read_n_in || !write_n_in);
        cnt_d = 4'h0;
        if (active) begin
            cnt_d = (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1;
        end
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    // acks rise at once when the command goes away
    assign early_ack_n_out = !(active && cnt_q >= ack_delay_in);
    assign transfer_ack_n_out = !(active && cnt_q >= ack_delay_in + 4'h4);
endmodule // lbc_ram_model

// *** verif/testbench.sv ***
// Purpose: self-checking bench for the local bus control block
// Assumes: a short watchdog count stands in for 10 ms
// Notes:   inputs change on the falling edge, outputs are read there too
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned TMO = 20;
    logic mclk_in, rst_in, ale_in, local_ram_request_in, mem_ready_in;
    logic ready_link_en_in, irq_route_en_in, command_n_out, io_cycle_out;
    logic io_write_strobe_n_out, mem_cycle_out, memory_write_strobe_n_out;
    logic memory_read_strobe_n_out, bus_timeout_out, hang_irq_out, cpu_ready_out;
    logic bus_transfer_ack_n_out, ext_owner_out, ram_early_ack_n_in, ram_transfer_ack_n_in;
    logic ctrl_port_select_n_out, external_select_n_out, ram_read_n_out, ram_write_n_out;
    logic cpu_ram_ack_n_out;
    logic [7:0] ad_in, addr_hi_in, addr_lo_out;
    logic [5:0] io_dec_addr_out, rom_dec_addr_out;
    logic [2:0] ram_dec_addr_out;
    logic [3:0] ack_delay;
    lbc_pkg::lbc_cpu_t cpu_in;
    lbc_pkg::lbc_ext_t ext_in;
    lbc_pkg::lbc_early_t early_out;
    int errors = 0;
    int tests_run = 0;
    int n;
    lbc_top #(.TIMEOUT_CYCLES(TMO)) uut (.mclk_in, .rst_in, .ale_in, .ad_in, .addr_hi_in,
        .cpu_in, .local_ram_request_in, .mem_ready_in, .ready_link_en_in, .irq_route_en_in,
        .addr_lo_out, .io_dec_addr_out, .rom_dec_addr_out, .ram_dec_addr_out, .command_n_out,
        .io_cycle_out, .io_write_strobe_n_out, .mem_cycle_out, .memory_write_strobe_n_out,
        .memory_read_strobe_n_out, .early_out, .bus_timeout_out, .hang_irq_out,
        .cpu_ready_out, .ext_in, .bus_transfer_ack_n_out, .ext_owner_out,
        .ram_early_ack_n_in, .ram_transfer_ack_n_in, .ctrl_port_select_n_out,
        .external_select_n_out, .ram_read_n_out, .ram_write_n_out, .cpu_ram_ack_n_out);
    lbc_ram_model ram_ctrl (.mclk_in, .rst_in, .port_select_n_in(ctrl_port_select_n_out),
        .read_n_in(ram_read_n_out), .write_n_in(ram_write_n_out), .ack_delay_in(ack_delay),
        .early_ack_n_out(ram_early_ack_n_in), .transfer_ack_n_out(ram_transfer_ack_n_in));
    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    initial begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge mclk_in);
    endtask
    // two strobe-high cycles so the completion flag is gone before the fall
    task automatic ale_cycle(input logic [7:0] a);
        ad_in = a;
        ale_in = 1'b1;
        cyc(2);
        ale_in = 1'b0;
        ad_in = ~a;
        cyc(1);
    endtask
    task automatic print_verdict;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_latch;
        addr_hi_in = 8'ha7;
        ale_cycle(8'hb4);
        chk("addr_lo", 8'hb4, addr_lo_out);
        chk("io_dec", 8'h2d, {2'b00, io_dec_addr_out});
        chk("rom_dec", 8'h29, {2'b00, rom_dec_addr_out});
        chk("ram_dec", 8'h05, {5'b00000, ram_dec_addr_out});
    endtask
    task automatic test_gates;
        for (int i = 0; i < 8; i++) begin
            cpu_in.iom = i[2];
            cpu_in.rd_n = i[1];
            cpu_in.wr_n = i[0];
            cyc(1);
            chk("command_n", {7'h0, i[1] & i[0]}, {7'h0, command_n_out});
            chk("io_cycle", {7'h0, i[2]}, {7'h0, io_cycle_out});
            chk("io_wr_n", {7'h0, ~(i[2] & ~i[0])}, {7'h0, io_write_strobe_n_out});
            chk("mem_cycle", {7'h0, ~i[2]}, {7'h0, mem_cycle_out});
            chk("mem_wr_n", {7'h0, i[2] | i[0]}, {7'h0, memory_write_strobe_n_out});
            chk("mem_rd_n", {7'h0, i[2] | i[1]}, {7'h0, memory_read_strobe_n_out});
        end
        cpu_in = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        cyc(1);
    endtask
    // every status code in io and memory cycles, each finished by a read strobe
    task automatic test_early;
        for (int i = 0; i < 8; i++) begin
            cpu_in = '{i[2], i[1], i[0], 1'b1, 1'b1};
            ale_cycle(8'h10);
            cyc(2);
            chk("early_rd_n", {7'h0, ~(~i[2] & i[1])}, {7'h0, early_out.early_read_cmd_n});
            chk("early_wr_n", {7'h0, ~(~i[2] & i[0] & ~i[1])}, {7'h0, early_out.early_write_cmd_n});
            cpu_in.rd_n = 1'b0;
            cyc(1);
            cpu_in.rd_n = 1'b1;
            cyc(3);
            chk("early_done", 8'h03, {6'h0, early_out});
        end
        cpu_in = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    endtask
    task automatic test_watchdog;
        for (int r = 1; r >= 0; r--) begin
            irq_route_en_in = r[0];
            ale_cycle(8'h00);
            cyc(TMO / 2);
            chk("tmo_early", 8'h00, {7'h0, bus_timeout_out});
            cyc(TMO);
            chk("tmo_set", 8'h01, {7'h0, bus_timeout_out});
            chk("ready_link", 8'h01, {7'h0, cpu_ready_out});
            ready_link_en_in = 1'b0;
            cyc(1);
            chk("ready_nolink", 8'h00, {7'h0, cpu_ready_out});
            ready_link_en_in = 1'b1;
            ale_in = 1'b1;
            cyc(1);
            ale_in = 1'b0;
            n = 0;
            repeat (5) begin
                n += int'(hang_irq_out);
                cyc(1);
            end
            chk("hang_irq", 8'(r), 8'(n));
            chk("tmo_clear", 8'h00, {7'h0, bus_timeout_out});
        end
    endtask
    // external access, with the cpu asking for ram while the master owns it
    task automatic test_ext(input logic wr);
        ack_delay = wr ? 4'h3 : 4'h1;
        ext_in = '{1'b0, wr, ~wr};
        n = 0;
        while (ext_owner_out !== 1'b1 && n < 10) begin
            cyc(1);
            n++;
        end
        chk("owner_delay", 8'h02, 8'(n));
        chk("sel_early", 8'h01, {7'h0, external_select_n_out});
        local_ram_request_in = 1'b1;
        cyc(1);
        chk("sel_set", 8'h00, {7'h0, external_select_n_out});
        chk("port_sel", 8'h00, {7'h0, ctrl_port_select_n_out});
        n = 0;
        while (bus_transfer_ack_n_out !== 1'b0 && n < 20) begin
            cyc(1);
            n++;
        end
        chk("ram_cmd", {6'h0, wr, ~wr}, {6'h0, ram_read_n_out, ram_write_n_out});
        chk("xack", 8'h00, {7'h0, bus_transfer_ack_n_out});
        chk("cpu_held", 8'h01, {7'h0, cpu_ram_ack_n_out});
        ext_in = 3'b011;
        cyc(1);
        ext_in = 3'b111;
        cyc(1);
        chk("owner_drop", 8'h00, {7'h0, ext_owner_out});
        chk("sel_hold", 8'h00, {7'h0, external_select_n_out});
        cyc(1);
        chk("sel_drop", 8'h01, {7'h0, external_select_n_out});
        local_ram_request_in = 1'b0;
        cyc(2);
    endtask
    // cpu and master ask in the same cycle; the master resumes afterwards
    task automatic test_cpu_prio;
        ack_delay = 4'h1;
        cpu_in.wr_n = 1'b0;
        local_ram_request_in = 1'b1;
        ext_in = 3'b010;
        cyc(1);
        chk("cpu_wr", 8'h00, {7'h0, ram_write_n_out});
        chk("cpu_port", 8'h00, {7'h0, ctrl_port_select_n_out});
        cyc(2);
        chk("cpu_ack", 8'h00, {7'h0, cpu_ram_ack_n_out});
        cyc(6);
        chk("ext_wait", 8'h01, {7'h0, external_select_n_out});
        chk("ext_owner", 8'h00, {7'h0, ext_owner_out});
        cpu_in.wr_n = 1'b1;
        local_ram_request_in = 1'b0;
        n = 0;
        while (ext_owner_out !== 1'b1 && n < 10) begin
            cyc(1);
            n++;
        end
        chk("ext_resume", 8'h02, 8'(n));
        ext_in = 3'b111;
        cyc(5);
        chk("ext_done", 8'h01, {7'h0, external_select_n_out});
    endtask
    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        rst_in = 1'b1;
        ale_in = 1'b0;
        ad_in = 8'h00;
        addr_hi_in = 8'h00;
        cpu_in = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        ext_in = 3'b111;
        local_ram_request_in = 1'b0;
        mem_ready_in = 1'b0;
        ready_link_en_in = 1'b1;
        irq_route_en_in = 1'b1;
        ack_delay = 4'h1;
        cyc(12);
        chk("rst_early", 8'h03, {6'h0, early_out});
        chk("rst_owner", 8'h00, {7'h0, ext_owner_out});
        chk("rst_sel", 8'h01, {7'h0, external_select_n_out});
        rst_in = 1'b0;
        cyc(1);
        test_latch();
        test_gates();
        test_early();
        test_watchdog();
        test_ext(1'b0);
        test_ext(1'b1);
        test_cpu_prio();
        print_verdict();
    end
    // tests take a few hundred cycles; this cuts off a hang
    initial begin
        #200us;
        errors++;
        print_verdict();
    end
endmodule // testbench
